//--- design/nfcie_apb_slave.sv
`timescale 1ns/1ps
module nfcie_apb_slave
  import nfcie_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output nfcie_req_s       req_o,
  output logic             pready_o
);

  logic pready_reg;
  logic pready_next;

  // Answer one cycle into the access phase
  always_comb begin
    pready_next = psel_i & penable_i & ~pready_reg;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
    end
  end

  // Write strobe valid in the completing cycle, read strobe in the access cycle before it
  always_comb begin
    req_o.wr    = psel_i & penable_i & pready_reg & pwrite_i;
    req_o.rd    = psel_i & penable_i & ~pready_reg & ~pwrite_i;
    req_o.addr  = paddr_i;
    req_o.wdata = pwdata_i;
  end

  assign pready_o = pready_reg;

endmodule : nfcie_apb_slave

//--- design/nfcie_pkg.sv
package nfcie_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] NFCIE_OFS_PLAIN  = 12'h300;
  localparam logic [11:0] NFCIE_OFS_SET    = 12'h304;
  localparam logic [11:0] NFCIE_OFS_CLEAR  = 12'h308;
  localparam logic [11:0] NFCIE_OFS_STATUS = 12'h30C;
  localparam logic [11:0] NFCIE_OFS_MASK   = 12'h310;
  localparam int          NFCIE_ADDR_W     = 12;

  // ****************************************************************
  // Enable field positions
  // ****************************************************************
  localparam int NFCIE_BIT_READY       = 0;
  localparam int NFCIE_BIT_FIELD_FOUND = 1;
  localparam int NFCIE_BIT_FIELD_GONE  = 2;
  localparam int NFCIE_BIT_SEND_BEGIN  = 3;
  localparam int NFCIE_BIT_SEND_FINISH = 4;
  localparam int NFCIE_BIT_RECV_BEGIN  = 5;
  localparam int NFCIE_BIT_RECV_FINISH = 6;
  localparam int NFCIE_BIT_ERROR       = 7;
  localparam int NFCIE_BIT_RECV_FAULT  = 10;
  localparam int NFCIE_BIT_RECV_FULL   = 11;
  localparam int NFCIE_BIT_SEND_DONE   = 12;
  localparam int NFCIE_BIT_ANTICOL_BEG = 14;
  localparam int NFCIE_BIT_COLLISION   = 18;
  localparam int NFCIE_BIT_ANTICOL_END = 19;
  localparam int NFCIE_BIT_DMA_START   = 20;

  // Implemented enable bits
  localparam logic [31:0] NFCIE_VALID_MASK = 32'h001C5CFF;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] NFCIE_RST_ENABLE = 32'h00000000;
  localparam logic [31:0] NFCIE_RST_STATUS = 32'h00000000;
  localparam logic [31:0] NFCIE_RST_MASK   = 32'h00000000;

  // ****************************************************************
  // Bus request carrier
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } nfcie_req_s;

endpackage : nfcie_pkg

//--- design/nfcie_top.sv
// Overview of operation
// - Writing one to a set-register bit enables that event's interrupt only.
// - Fifteen enable bits: ready, field, frames, errors, buffers, anticollision, DMA.
// - Reading set or clear register returns the current enable bits.
// - Set register sits at offset 0x304.
// - Clear register sits at offset 0x308.
// - Disabled enable bits read back as zero.
// - Set and clear act on the plain enable register at 0x300.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module nfcie_top
  import nfcie_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [31:0] event_i,
  output logic      [31:0] irq_enable_o,
  output logic             irq_o
);

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  nfcie_req_s req;

  nfcie_apb_slave u_slave (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .req_o     (req),
    .pready_o  (pready_o)
  );

  // Offset decode, shared by read and write paths
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == NFCIE_OFS_PLAIN) || (a == NFCIE_OFS_SET) || (a == NFCIE_OFS_CLEAR)
             || (a == NFCIE_OFS_STATUS) || (a == NFCIE_OFS_MASK);
  endfunction : is_mapped

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic        irq_reg;
  logic        irq_next;
  logic [31:0] wmask;

  assign wmask = req.wdata & NFCIE_VALID_MASK;

  // Enable bits: plain write, set-ones, clear-ones
  always_comb begin
    enable_next = enable_reg;
    if (req.wr) begin
      case (req.addr)
        NFCIE_OFS_PLAIN: enable_next = wmask;
        NFCIE_OFS_SET:   enable_next = enable_reg | wmask;
        NFCIE_OFS_CLEAR: enable_next = enable_reg & ~wmask;
        default:         enable_next = enable_reg;
      endcase
    end
  end

  // Sticky event status, set wins over write-one-to-clear; mask register
  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    if (req.wr && req.addr == NFCIE_OFS_STATUS) begin
      status_next = status_reg & ~wmask;
    end
    if (req.wr && req.addr == NFCIE_OFS_MASK) begin
      mask_next = wmask;
    end
    status_next = status_next | (event_i & enable_reg & NFCIE_VALID_MASK);
  end

  // Read data and error answer
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = 1'b0;
    if (req.rd) begin
      case (req.addr)
        NFCIE_OFS_PLAIN,
        NFCIE_OFS_SET,
        NFCIE_OFS_CLEAR:  rdata_next = enable_reg;
        NFCIE_OFS_STATUS: rdata_next = status_reg;
        NFCIE_OFS_MASK:   rdata_next = mask_reg;
        default:          rdata_next = 32'h00000000;
      endcase
      err_next = ~is_mapped(req.addr);
    end else if (req.wr) begin
      err_next = 1'b0;
    end
    if (psel_i && penable_i && !pready_o) begin
      err_next = ~is_mapped(req.addr);
    end
  end

  // Interrupt level from unmasked status
  always_comb begin
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      enable_reg <= NFCIE_RST_ENABLE;
      status_reg <= NFCIE_RST_STATUS;
      mask_reg   <= NFCIE_RST_MASK;
      rdata_reg  <= 32'h00000000;
      err_reg    <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
      irq_reg    <= irq_next;
    end
  end

  assign prdata_o     = rdata_reg;
  assign pslverr_o    = err_reg;
  assign irq_enable_o = enable_reg;
  assign irq_o        = irq_reg;

endmodule : nfcie_top

//--- verif/nfc_tag_irq_enable_set_clear_tb_top.sv
`timescale 1ns/1ps
module nfc_tag_irq_enable_set_clear_tb_top
  import nfcie_pkg::*;
;
  logic        clock_i = 1'h0, sys_rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, event_i = 32'h0, prdata_o, irq_enable_o, rd, ex;
  logic        pready_o, pslverr_o, irq_o, er;
  int          n_errors = 0, cmp_count = 0;
  // Clock
  always #5 clock_i = ~clock_i;
  nfcie_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .event_i(event_i), .irq_enable_o(irq_enable_o), .irq_o(irq_o));
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One APB transfer, idle cycle after
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t = 0;
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clock_i);
      t++;
    end while (pready_o !== 1'h1 && t < 50);
    if (t >= 50) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clock_i);
  endtask : apb
  // One-cycle event pulse, then wait for the level to land
  task automatic pulse(input logic [31:0] e);
    event_i <= e;
    @(posedge clock_i);
    event_i <= 32'h0;
    repeat (2) @(posedge clock_i);
  endtask : pulse
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Watchdog
  initial begin
    repeat (3000) @(posedge clock_i);
    n_errors++;
    results();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    @(posedge clock_i);
    apb(1'h0, NFCIE_OFS_CLEAR, 32'h0);
    chk(rd, 32'h0);
    ex = 32'h0;
    for (int i = 0; i < 32; i++) begin
      apb(1'h1, NFCIE_OFS_SET, 32'h1 << i);
      ex |= (32'h1 << i) & NFCIE_VALID_MASK;
      apb(1'h0, NFCIE_OFS_SET, 32'h0);
      chk(rd, ex);
      apb(1'h0, NFCIE_OFS_CLEAR, 32'h0);
      chk(rd, ex);
    end
    apb(1'h1, NFCIE_OFS_SET, 32'h0);
    apb(1'h1, NFCIE_OFS_CLEAR, 32'h0);
    chk(irq_enable_o, ex);
    apb(1'h1, NFCIE_OFS_CLEAR, 32'h55555555);
    apb(1'h0, NFCIE_OFS_SET, 32'h0);
    chk(rd, ex & 32'hAAAAAAAA);
    apb(1'h1, NFCIE_OFS_PLAIN, 32'hFFFFFFFF);
    apb(1'h0, NFCIE_OFS_CLEAR, 32'h0);
    chk(rd, NFCIE_VALID_MASK);
    apb(1'h1, NFCIE_OFS_CLEAR, 32'hFFFFFFFF);
    apb(1'h0, NFCIE_OFS_PLAIN, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h3FC, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'h1, NFCIE_OFS_MASK, 32'hFFFFFFFF);
    pulse(32'h1 << NFCIE_BIT_READY);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'h1, NFCIE_OFS_SET, 32'h1 << NFCIE_BIT_ERROR);
    pulse(32'h1 << NFCIE_BIT_ERROR);
    chk({31'h0, irq_o}, 32'h1);
    apb(1'h1, NFCIE_OFS_STATUS, 32'h1 << NFCIE_BIT_ERROR);
    @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'h1, NFCIE_OFS_MASK, 32'h0);
    pulse(32'h1 << NFCIE_BIT_ERROR);
    chk({31'h0, irq_o}, 32'h0);
    results();
  end
endmodule : nfc_tag_irq_enable_set_clear_tb_top

//--- verif/nfcie_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// Enable state checks at the top ports
// ****************************************************************
module nfcie_checker
  import nfcie_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic [31:0] irq_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Completed transfer at this edge
  wire logic acc = psel_i && penable_i && pready_o;
  chk_set_ors: assert property (acc && pwrite_i && paddr_i == NFCIE_OFS_SET |=>
    irq_enable_o == ($past(irq_enable_o) | ($past(pwdata_i) & NFCIE_VALID_MASK))) else $error("set write wrong");
  chk_clear_ands: assert property (acc && pwrite_i && paddr_i == NFCIE_OFS_CLEAR |=>
    irq_enable_o == ($past(irq_enable_o) & ~$past(pwdata_i))) else $error("clear write wrong");
  chk_plain_load: assert property (acc && pwrite_i && paddr_i == NFCIE_OFS_PLAIN |=>
    irq_enable_o == ($past(pwdata_i) & NFCIE_VALID_MASK)) else $error("plain write wrong");
  chk_read_set: assert property (acc && !pwrite_i && paddr_i == NFCIE_OFS_SET |->
    prdata_o == irq_enable_o) else $error("set read wrong");
  chk_read_clear: assert property (acc && !pwrite_i && paddr_i == NFCIE_OFS_CLEAR |->
    prdata_o == irq_enable_o) else $error("clear read wrong");
  chk_valid_bits: assert property ((irq_enable_o & ~NFCIE_VALID_MASK) == 32'h0)
    else $error("unimplemented enable bit set");
  chk_idle_hold: assert property (!(acc && pwrite_i) |=> $stable(irq_enable_o))
    else $error("enables moved without write");
  chk_reset_off: assert property (disable iff (1'b0) sys_rst_i |=> irq_enable_o == NFCIE_RST_ENABLE)
    else $error("enables not cleared by reset");
endmodule : nfcie_checker

bind nfcie_top nfcie_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .irq_enable_o(irq_enable_o));
